// *** i2c_tgt_regs.vh ***
`ifndef I2C_TGT_REGS_VH
`define I2C_TGT_REGS_VH

// Target address and direction
`define TGT_ADDR 7'h68
`define DIR_READ 1'b1

// Register pointer
`define PTR_W 3
`define PTR_FIRST 3'h0
`define PTR_LAST 3'h5
`define PTR_RESET 3'h0

// Byte framing
`define BIT_LAST 4'h7
`define BIT_ACK 4'h8

// Timing, core clock 20 MHz
`define CLK_PERIOD_NS 50
`define SPIKE_NS 50
`define HOLD_NS 300
`define FILT_CYC (`SPIKE_NS / `CLK_PERIOD_NS)
`define HOLD_CYC ((`HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Write buffer
`define WR_WORD_W 11
`define FIFO_DEPTH 8
`define FIFO_AW 3

`endif

// *** wr_byte_fifo.v ***
`timescale 1ns/1ps

module wr_byte_fifo #(
    parameter WIDTH = 11,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire i_core_clk,
    input wire i_srst,
    input wire i_in_valid,
    output wire o_in_ready,
    input wire [WIDTH-1:0] i_in_data,
    output wire o_out_valid,
    input wire i_out_ready,
    output wire [WIDTH-1:0] o_out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_ptr;
    reg [AW:0] rd_ptr;
    wire full;
    wire empty;

    assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign empty = (wr_ptr == rd_ptr);
    assign o_in_ready = ~full;
    assign o_out_valid = ~empty;
    assign o_out_data = mem[rd_ptr[AW-1:0]];

    always @(posedge i_core_clk) begin
        if (i_in_valid && !full) begin
            mem[wr_ptr[AW-1:0]] <= i_in_data;
        end
    end

    always @(posedge i_core_clk) begin
        if (i_srst) begin
            wr_ptr <= {(AW+1){1'b0}};
            rd_ptr <= {(AW+1){1'b0}};
        end else begin
            if (i_in_valid && !full) begin
                wr_ptr <= wr_ptr + {{AW{1'b0}}, 1'b1};
            end
            if (i_out_ready && !empty) begin
                rd_ptr <= rd_ptr + {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule

// *** i2c_target_port.v ***
`timescale 1ns/1ps
`include "i2c_tgt_regs.vh"

module i2c_target_port (
    input wire i_core_clk,
    input wire i_srst,
    input wire i_scl,
    input wire i_sda,
    input wire i_pwr_fail,
    input wire [7:0] i_rd_data,
    input wire i_wr_ready,
    output reg o_sda_out,
    output reg o_sda_oe,
    output wire [`PTR_W-1:0] o_rd_addr,
    output wire o_wr_valid,
    output wire [`PTR_W-1:0] o_wr_addr,
    output wire [7:0] o_wr_data,
    output reg o_addressed,
    output reg o_read_mode,
    output reg o_bus_busy,
    output reg o_overflow
);
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_ADDR_ACK = 3'h2;
    localparam ST_RX = 3'h3;
    localparam ST_RX_ACK = 3'h4;
    localparam ST_TX = 3'h5;
    localparam ST_TX_ACK = 3'h6;
    localparam [31:0] FILT_FULL = `FILT_CYC;
    localparam [31:0] HOLD_FULL = `HOLD_CYC;
    localparam [3:0] FILT_CYC = FILT_FULL[3:0];
    localparam [3:0] HOLD_CYC = HOLD_FULL[3:0];
    // Pointer step with wrap past the last location
    function [`PTR_W-1:0] ptr_inc;
        input [`PTR_W-1:0] p;
        begin
            if (p >= `PTR_LAST) begin
                ptr_inc = `PTR_FIRST;
            end else begin
                ptr_inc = p + 3'h1;
            end
        end
    endfunction

    // Glitch filter step: {filtered, count}
    function [4:0] filt_step;
        input cur;
        input smp;
        input [3:0] cnt;
        begin
            if (smp == cur) begin
                filt_step = {cur, 4'h0};
            end else if (cnt >= FILT_CYC) begin
                filt_step = {smp, 4'h0};
            end else begin
                filt_step = {cur, cnt + 4'h1};
            end
        end
    endfunction

    reg scl_s1;
    reg scl_s2;
    reg sda_s1;
    reg sda_s2;
    reg scl_f;
    reg sda_f;
    reg scl_d;
    reg sda_d;
    reg [3:0] scl_fcnt;
    reg [3:0] sda_fcnt;
    wire [4:0] next_scl_filt;
    wire [4:0] next_sda_filt;

    reg [2:0] state;
    reg [3:0] bit_cnt;
    reg [7:0] shift;
    reg [`PTR_W-1:0] ptr;
    reg ptr_phase;
    reg nack_seen;
    reg pend_oe;
    reg hold_pend;
    reg [3:0] hold_cnt;

    wire scl_rise;
    wire scl_fall;
    wire start_cond;
    wire stop_cond;
    wire byte_done;
    wire push_try;
    wire fifo_ready;

    // Two flops per line before any logic looks at the bus
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
        end else begin
            scl_s1 <= i_scl;
            scl_s2 <= scl_s1;
            sda_s1 <= i_sda;
            sda_s2 <= sda_s1;
        end
    end

    assign next_scl_filt = filt_step(scl_f, scl_s2, scl_fcnt);
    assign next_sda_filt = filt_step(sda_f, sda_s2, sda_fcnt);

    // Spike rejection; 50 ns budget is one core cycle, well inside fast-mode timing
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            scl_f <= 1'b1;
            sda_f <= 1'b1;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            scl_fcnt <= 4'h0;
            sda_fcnt <= 4'h0;
        end else begin
            scl_f <= next_scl_filt[4];
            scl_fcnt <= next_scl_filt[3:0];
            sda_f <= next_sda_filt[4];
            sda_fcnt <= next_sda_filt[3:0];
            scl_d <= scl_f;
            sda_d <= sda_f;
        end
    end

    assign scl_rise = scl_f & ~scl_d;
    assign scl_fall = ~scl_f & scl_d;
    assign start_cond = scl_f & scl_d & sda_d & ~sda_f;
    assign stop_cond = scl_f & scl_d & ~sda_d & sda_f;
    assign byte_done = scl_fall && (bit_cnt == `BIT_ACK);

    // Written bytes head for the core through the buffer
    assign push_try = (state == ST_RX) && byte_done && !ptr_phase && !i_pwr_fail && !start_cond && !stop_cond;
    assign o_rd_addr = ptr;

    wr_byte_fifo #(
        .WIDTH(`WR_WORD_W),
        .DEPTH(`FIFO_DEPTH),
        .AW(`FIFO_AW)
    ) u_wr_fifo (
        .i_core_clk(i_core_clk),
        .i_srst(i_srst),
        .i_in_valid(push_try),
        .o_in_ready(fifo_ready),
        .i_in_data({ptr, shift}),
        .o_out_valid(o_wr_valid),
        .i_out_ready(i_wr_ready),
        .o_out_data({o_wr_addr, o_wr_data})
    );

    // Queue a data-line change; applied after the hold delay, while the clock is low except for the power-fail release in ST_TX
    task sched_sda;
        input drive_low;
        begin
            pend_oe <= drive_low;
            hold_pend <= 1'b1;
            hold_cnt <= HOLD_CYC;
        end
    endtask

    always @(posedge i_core_clk) begin
        if (i_srst) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            ptr <= `PTR_RESET;
            ptr_phase <= 1'b0;
            nack_seen <= 1'b0;
            pend_oe <= 1'b0;
            hold_pend <= 1'b0;
            hold_cnt <= 4'h0;
            o_sda_out <= 1'b0;
            o_sda_oe <= 1'b0;
            o_addressed <= 1'b0;
            o_read_mode <= 1'b0;
            o_bus_busy <= 1'b0;
            o_overflow <= 1'b0;
        end else begin
            // Open drain: only ever pulls low, clock line never driven
            o_sda_out <= 1'b0;
            o_overflow <= 1'b0;
            if (hold_pend) begin
                if (hold_cnt <= 4'h1) begin
                    o_sda_oe <= pend_oe;
                    hold_pend <= 1'b0;
                end else begin
                    hold_cnt <= hold_cnt - 4'h1;
                end
            end
            if (start_cond) begin
                // Also covers repeated START mid-transfer
                o_bus_busy <= 1'b1;
                state <= ST_ADDR;
                bit_cnt <= 4'h0;
                o_sda_oe <= 1'b0;
                hold_pend <= 1'b0;
                o_addressed <= 1'b0;
            end else if (stop_cond) begin
                o_bus_busy <= 1'b0;
                state <= ST_IDLE;
                o_sda_oe <= 1'b0;
                hold_pend <= 1'b0;
                o_addressed <= 1'b0;
            end else begin
                case (state)
                    ST_IDLE: begin
                        bit_cnt <= 4'h0;
                    end
                    ST_ADDR: begin
                        if (scl_rise) begin
                            shift <= {shift[6:0], sda_f};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (byte_done) begin
                            if (shift[7:1] == `TGT_ADDR && !i_pwr_fail) begin
                                o_read_mode <= shift[0];
                                o_addressed <= 1'b1;
                                sched_sda(1'b1);
                                state <= ST_ADDR_ACK;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                    ST_ADDR_ACK: begin
                        if (scl_fall) begin
                            bit_cnt <= 4'h0;
                            if (o_read_mode == `DIR_READ) begin
                                shift <= i_rd_data;
                                sched_sda(~i_rd_data[7]);
                                state <= ST_TX;
                            end else begin
                                sched_sda(1'b0);
                                ptr_phase <= 1'b1;
                                state <= ST_RX;
                            end
                        end
                    end
                    ST_RX: begin
                        if (scl_rise) begin
                            shift <= {shift[6:0], sda_f};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (byte_done) begin
                            if (ptr_phase) begin
                                // Out-of-range pointer values fold to location zero
                                if (shift[7:0] > {5'h00, `PTR_LAST}) begin
                                    ptr <= `PTR_FIRST;
                                end else begin
                                    ptr <= shift[`PTR_W-1:0];
                                end
                                ptr_phase <= 1'b0;
                                sched_sda(1'b1);
                                state <= ST_RX_ACK;
                            end else if (!i_pwr_fail && fifo_ready) begin
                                ptr <= ptr_inc(ptr);
                                sched_sda(1'b1);
                                state <= ST_RX_ACK;
                            end else begin
                                // Full buffer or power fail: refuse the byte, drop the rest
                                o_overflow <= ~i_pwr_fail;
                                o_addressed <= 1'b0;
                                state <= ST_IDLE;
                            end
                        end
                    end
                    ST_RX_ACK: begin
                        if (scl_fall) begin
                            sched_sda(1'b0);
                            bit_cnt <= 4'h0;
                            state <= ST_RX;
                        end
                    end
                    ST_TX: begin
                        if (i_pwr_fail) begin
                            sched_sda(1'b0);
                            o_addressed <= 1'b0;
                            state <= ST_IDLE;
                        end else if (scl_fall) begin
                            if (bit_cnt == `BIT_LAST) begin
                                sched_sda(1'b0);
                                ptr <= ptr_inc(ptr);
                                nack_seen <= 1'b1;
                                state <= ST_TX_ACK;
                            end else begin
                                shift <= {shift[6:0], 1'b0};
                                sched_sda(~shift[6]);
                                bit_cnt <= bit_cnt + 4'h1;
                            end
                        end
                    end
                    ST_TX_ACK: begin
                        if (scl_rise) begin
                            nack_seen <= sda_f;
                        end else if (scl_fall) begin
                            bit_cnt <= 4'h0;
                            if (nack_seen || i_pwr_fail) begin
                                o_addressed <= 1'b0;
                                state <= ST_IDLE;
                            end else begin
                                shift <= i_rd_data;
                                sched_sda(~i_rd_data[7]);
                                state <= ST_TX;
                            end
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end
endmodule

// *** i2c_port_asserts.sv ***
`timescale 1ns/1ps
`include "i2c_tgt_regs.vh"
module i2c_port_asserts (
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_pwr_fail,
    input wire logic o_sda_out,
    input wire logic o_sda_oe,
    input wire logic [`PTR_W-1:0] o_rd_addr,
    input wire logic o_wr_valid,
    input wire logic o_addressed,
    input wire logic o_bus_busy,
    input wire logic o_overflow
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_srst);
    sequence s_start;
        i_scl && $fell(i_sda);
    endsequence
    sequence s_stop;
        i_scl && $rose(i_sda);
    endsequence
    property p_drive_low;
        o_sda_out == 1'b0;
    endproperty
    a_drive_low: assert property (p_drive_low) else $error("sda value not low");
    // Pin to decision takes about five cycles
    property p_start_busy;
        s_start |-> ##[1:8] o_bus_busy;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("start missed");
    property p_stop_idle;
        s_stop |-> ##[1:8] (!o_bus_busy && !o_addressed);
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stop missed");
    property p_oe_low_phase;
        $rose(o_sda_oe) |-> !i_scl;
    endproperty
    a_oe_low_phase: assert property (p_oe_low_phase) else $error("sda pulled with clock high");
    property p_ack_steady;
        o_sda_oe && $rose(i_scl) |-> o_sda_oe [*8];
    endproperty
    a_ack_steady: assert property (p_ack_steady) else $error("sda released in high phase");
    property p_ack_addr;
        $rose(o_addressed) |-> ##[0:40] o_sda_oe;
    endproperty
    a_ack_addr: assert property (p_ack_addr) else $error("address not acknowledged");
    property p_pwr_block;
        i_pwr_fail && $past(i_pwr_fail) |-> !$rose(o_addressed);
    endproperty
    a_pwr_block: assert property (p_pwr_block) else $error("addressed in power fail");
    property p_ovf_pulse;
        o_overflow |-> o_wr_valid ##1 !o_overflow;
    endproperty
    a_ovf_pulse: assert property (p_ovf_pulse) else $error("overflow pulse wrong");
    property p_ptr_range;
        o_rd_addr <= `PTR_LAST;
    endproperty
    a_ptr_range: assert property (p_ptr_range) else $error("pointer out of range");
endmodule

// *** i2c_master_model.sv ***
`timescale 1ns/1ps
module i2c_master_model (
    input wire logic i_core_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_low
);
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    // Pin changes land just after a core edge, never on it
    task automatic wt(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask
    // Low phase 30 cycles, as the target answers 11 cycles into it
    task automatic bit_io(input logic d, output logic q);
        wt(4);
        o_sda_low = ~d;
        wt(26);
        o_scl = 1'b1;
        wt(10);
        q = i_sda;
        wt(10);
        o_scl = 1'b0;
    endtask
    task automatic start;
        if (!o_scl) begin
            o_sda_low = 1'b0;
            wt(26);
            o_scl = 1'b1;
        end
        wt(12);
        o_sda_low = 1'b1;
        wt(12);
        o_scl = 1'b0;
    endtask
    task automatic stop;
        wt(4);
        o_sda_low = 1'b1;
        wt(26);
        o_scl = 1'b1;
        wt(12);
        o_sda_low = 1'b0;
        wt(20);
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic q;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], q);
        bit_io(1'b1, q);
        ack = ~q;
    endtask
    task automatic rbyte(input logic ack_it, output logic [7:0] b);
        logic q;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, b[i]);
        bit_io(~ack_it, q);
    endtask
endmodule

// *** tb.sv ***
`timescale 1ns/1ps
`include "i2c_tgt_regs.vh"
module tb;
    logic i_core_clk = 1'b0;
    logic i_srst = 1'b1;
    logic i_pwr_fail = 1'b0;
    logic i_wr_ready = 1'b1;
    logic i_scl, i_sda, m_low, o_sda_out, o_sda_oe, o_wr_valid;
    logic o_addressed, o_read_mode, o_bus_busy, o_overflow;
    logic [2:0] o_rd_addr, o_wr_addr;
    logic [7:0] i_rd_data, o_wr_data;
    logic [10:0] got[$];
    int bad_count = 0;
    int num_checks = 0;
    int ovf = 0;
    always #25 i_core_clk = ~i_core_clk;
    // Pull-up: released wire reads high
    assign i_sda = ~(o_sda_oe | m_low);
    // Distinct byte per location
    assign i_rd_data = {5'h1A, o_rd_addr};
    always @(posedge i_core_clk) begin
        if (o_wr_valid && i_wr_ready)
            got.push_back({o_wr_addr, o_wr_data});
        if (o_overflow)
            ovf++;
    end
    i2c_master_model u_mst (.i_core_clk, .i_sda, .o_scl(i_scl), .o_sda_low(m_low));
    i2c_target_port u_dut (.i_core_clk, .i_srst, .i_scl, .i_sda, .i_pwr_fail, .i_rd_data, .i_wr_ready,
        .o_sda_out, .o_sda_oe, .o_rd_addr, .o_wr_valid, .o_wr_addr, .o_wr_data, .o_addressed,
        .o_read_mode, .o_bus_busy, .o_overflow);
    task automatic chk(input logic [10:0] act, input logic [10:0] exp);
        num_checks++;
        if (act !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, act, exp);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic t_reset;
        repeat (4) @(posedge i_core_clk);
        #1;
        chk({o_sda_oe, o_bus_busy, o_addressed, o_wr_valid, o_read_mode, o_overflow, o_rd_addr}, 0);
        i_srst = 1'b0;
        u_mst.wt(6);
        chk({o_sda_oe, o_bus_busy}, 0);
        $display("reset test done");
    endtask
    task automatic t_write;
        logic a;
        logic [7:0] dv[3] = '{8'h3C, 8'hA5, 8'h0F};
        got.delete();
        u_mst.start();
        u_mst.wbyte({`TGT_ADDR, 1'b0}, a);
        chk(a, 1);
        u_mst.wbyte(8'h04, a);
        chk({a, o_rd_addr}, {1'b1, 3'h4});
        for (int k = 0; k < 3; k++) begin
            u_mst.wbyte(dv[k], a);
            chk(a, 1);
        end
        u_mst.stop();
        chk(11'(got.size()), 3);
        for (int k = 0; k < 3; k++)
            chk(got[k], {3'((4 + k) % 6), dv[k]});
        chk({o_bus_busy, o_rd_addr}, {1'b0, 3'h1});
        $display("write test done");
    endtask
    task automatic t_read;
        logic a;
        logic [7:0] b;
        u_mst.start();
        u_mst.wbyte({`TGT_ADDR, `DIR_READ}, a);
        chk({a, o_read_mode}, 2'b11);
        u_mst.rbyte(1'b1, b);
        chk(b, {5'h1A, 3'h1});
        u_mst.rbyte(1'b0, b);
        chk(b, {5'h1A, 3'h2});
        u_mst.wt(15);
        chk({o_sda_oe, o_addressed}, 0);
        u_mst.stop();
        $display("read test done");
    endtask
    task automatic t_rstart;
        logic a;
        logic [7:0] b;
        u_mst.start();
        u_mst.wbyte({`TGT_ADDR, 1'b0}, a);
        u_mst.wbyte(8'h05, a);
        u_mst.start();
        u_mst.wbyte({`TGT_ADDR, `DIR_READ}, a);
        chk(a, 1);
        u_mst.rbyte(1'b0, b);
        chk(b, {5'h1A, 3'h5});
        u_mst.stop();
        chk(o_rd_addr, 0);
        $display("repeated start test done");
    endtask
    task automatic t_miss;
        logic a;
        logic [7:0] b;
        u_mst.start();
        u_mst.wbyte(8'hA0, a);
        chk({a, o_addressed}, 0);
        u_mst.wbyte(8'h03, a);
        chk({a, o_rd_addr}, 0);
        u_mst.stop();
        i_pwr_fail = 1'b1;
        u_mst.start();
        u_mst.wbyte({`TGT_ADDR, 1'b0}, a);
        chk({a, o_addressed}, 0);
        u_mst.stop();
        i_pwr_fail = 1'b0;
        u_mst.start();
        u_mst.wbyte({`TGT_ADDR, 1'b0}, a);
        u_mst.wbyte(8'h02, a);
        got.delete();
        i_pwr_fail = 1'b1;
        u_mst.wbyte(8'h55, a);
        chk({a, 7'(got.size()), o_rd_addr}, {1'b0, 7'h00, 3'h2});
        u_mst.stop();
        i_pwr_fail = 1'b0;
        u_mst.start();
        u_mst.wbyte({`TGT_ADDR, `DIR_READ}, a);
        i_pwr_fail = 1'b1;
        u_mst.rbyte(1'b0, b);
        chk({b, o_addressed}, {8'hFF, 1'b0});
        u_mst.stop();
        i_pwr_fail = 1'b0;
        $display("refusal test done");
    endtask
    task automatic t_full;
        logic a;
        i_wr_ready = 1'b0;
        ovf = 0;
        got.delete();
        u_mst.start();
        u_mst.wbyte({`TGT_ADDR, 1'b0}, a);
        u_mst.wbyte(8'h00, a);
        for (int k = 0; k < 8; k++) begin
            u_mst.wbyte(8'(k), a);
            chk(a, 1);
        end
        u_mst.wbyte(8'hEE, a);
        chk({a, 10'(ovf)}, 1);
        u_mst.stop();
        i_wr_ready = 1'b1;
        for (int k = 0; k < 20 && o_wr_valid; k++)
            u_mst.wt(1);
        if (o_wr_valid) begin
            bad_count++;
            close_out();
        end
        chk(11'(got.size()), 8);
        chk(got[7], {3'h1, 8'h07});
        $display("buffer test done");
    endtask
    initial begin
        t_reset();
        t_write();
        t_read();
        t_rstart();
        t_miss();
        t_full();
        close_out();
    end
endmodule
bind i2c_target_port i2c_port_asserts u_chk (.i_core_clk, .i_srst, .i_scl, .i_sda, .i_pwr_fail, .o_sda_out,
    .o_sda_oe, .o_rd_addr, .o_wr_valid, .o_addressed, .o_bus_busy, .o_overflow);
